// file: acc_pkg.sv
// Package with register map, field layout, timing and state types of the converter control
`default_nettype none
package acc_pkg;
    // Register byte offsets
    localparam logic [4:0] ACC_OFF_CTRL = 5'h00;
    localparam logic [4:0] ACC_OFF_RESULT = 5'h04;
    localparam logic [4:0] ACC_OFF_CLKREG = 5'h08;
    localparam logic [4:0] ACC_OFF_IST = 5'h0c;
    localparam logic [4:0] ACC_OFF_IMASK = 5'h10;
    // Control register fields
    localparam int ACC_CTRL_DONE = 7;
    localparam int ACC_CTRL_IEN = 6;
    localparam int ACC_CTRL_CONT = 5;
    localparam int ACC_CTRL_CH_LSB = 0;
    localparam logic [4:0] ACC_CH_OFF = 5'h1f;
    localparam int ACC_NUM_CH = 16;
    // Clock register fields
    localparam int ACC_CLK_ASYNC_EN = 7;
    localparam int ACC_CLK_DIV_LSB = 5;
    localparam int ACC_CLK_LPC = 4;
    localparam int ACC_CLK_LSMP = 3;
    // Interrupt status bits
    localparam int ACC_EV_DONE = 0;
    localparam int ACC_EV_OVR = 1;
    localparam int ACC_EV_DIR = 2;
    localparam int ACC_NUM_EV = 3;
    // Reset values
    localparam logic [4:0] ACC_RST_CH = 5'h1f;
    localparam logic [1:0] ACC_RST_DIV = 2'h0;
    localparam logic [2:0] ACC_RST_IMASK = 3'h0;
    // Conversion timing in converter clock ticks
    localparam logic [4:0] ACC_WAKE_TK = 5'h03;
    localparam logic [4:0] ACC_SHORT_TK = 5'h03;
    localparam logic [4:0] ACC_LONG_TK = 5'h17;
    localparam logic [4:0] ACC_CONV_TK = 5'h12;
    // Internal asynchronous clock: system cycles per tick
    localparam logic [2:0] ACC_ASYNC_DIV = 3'h2;
    localparam logic [1:0] ACC_HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } acc_ahb_req_t;

    typedef struct packed {
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
    } acc_ahb_rsp_t;

    typedef enum logic [3:0] {
        ACC_ST_IDLE = 4'b0001,
        ACC_ST_WAKE = 4'b0010,
        ACC_ST_SAMP = 4'b0100,
        ACC_ST_CONV = 4'b1000
    } acc_seq_st_t;

    typedef struct packed {
        acc_seq_st_t st;
        logic [4:0] cnt;
    } acc_seq_s_t;

    typedef struct packed {
        logic [2:0] bus_cnt;
        logic [2:0] async_cnt;
    } acc_clk_s_t;

    typedef struct packed {
        logic wr_pend;
        logic [4:0] wr_off;
        logic [31:0] rdata;
        logic irq_en;
        logic cont;
        logic [4:0] chan;
        logic async_clock_enable;
        logic [1:0] div;
        logic lpc;
        logic lsmp;
        logic done;
        logic [9:0] result;
        logic [9:0] held;
        logic [2:0] ist;
        logic [2:0] imask;
        logic start;
        logic abort;
    } acc_regs_t;
endpackage
`default_nettype wire

// file: acc_clkgen.sv
// Converter clock tick generator: bus prescaler and internal asynchronous clock
`default_nettype none
module acc_clkgen (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic async_clock_enable,
    input wire logic [1:0] div,
    input wire logic stop_i,
    output logic tick
);
    import acc_pkg::*;
    acc_clk_s_t s_q;
    acc_clk_s_t s_d;
    logic [2:0] mask;
    logic bus_tick;
    logic async_tick;

    always_comb begin
        s_d = s_q;
        s_d.bus_cnt = s_q.bus_cnt + 3'h1;
        // Divide by 1, 2, 4 or 8 only; no divide-by-six
        mask = 3'((4'h1 << div) - 4'h1);
        bus_tick = (s_q.bus_cnt & mask) == 3'h0;
        async_tick = s_q.async_cnt == ACC_ASYNC_DIV - 3'h1;
        s_d.async_cnt = async_tick ? 3'h0 : s_q.async_cnt + 3'h1;
        // Bus clock stops in stop mode, the internal clock keeps running
        tick = async_clock_enable ? async_tick : (bus_tick & ~stop_i);
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule // acc_clkgen
`default_nettype wire

// file: acc_seq.sv
// Conversion sequencer: wake, sample and conversion phases counted in converter ticks
`default_nettype none
module acc_seq (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic tick,
    input wire logic start,
    input wire logic abort,
    input wire logic long_smp,
    input wire logic async_clock_enable,
    output logic busy,
    output logic sampling,
    output logic take,
    output logic done
);
    import acc_pkg::*;
    acc_seq_s_t s_q;
    acc_seq_s_t s_d;
    logic [4:0] samp_len;

    always_comb begin
        s_d = s_q;
        take = 1'b0;
        done = 1'b0;
        // Long sample trades conversion time for power
        samp_len = long_smp ? ACC_LONG_TK : ACC_SHORT_TK;
        if (start) begin
            // Async clock needs a wake phase, giving 24 to 44 ticks
            s_d.st = async_clock_enable ? ACC_ST_WAKE : ACC_ST_SAMP;
            s_d.cnt = async_clock_enable ? ACC_WAKE_TK - 5'h1 : samp_len - 5'h1;
        end else if (abort) begin
            s_d.st = ACC_ST_IDLE;
            s_d.cnt = 5'h0;
        end else if (tick) begin
            unique case (s_q.st)
                ACC_ST_IDLE: begin
                    s_d.cnt = 5'h0;
                end
                ACC_ST_WAKE: begin
                    if (s_q.cnt == 5'h0) begin
                        s_d.st = ACC_ST_SAMP;
                        s_d.cnt = samp_len - 5'h1;
                    end else begin
                        s_d.cnt = s_q.cnt - 5'h1;
                    end
                end
                ACC_ST_SAMP: begin
                    if (s_q.cnt == 5'h0) begin
                        take = 1'b1;
                        s_d.st = ACC_ST_CONV;
                        s_d.cnt = ACC_CONV_TK - 5'h1;
                    end else begin
                        s_d.cnt = s_q.cnt - 5'h1;
                    end
                end
                ACC_ST_CONV: begin
                    if (s_q.cnt == 5'h0) begin
                        done = 1'b1;
                        s_d.st = ACC_ST_IDLE;
                    end else begin
                        s_d.cnt = s_q.cnt - 5'h1;
                    end
                end
                default: begin
                    s_d.st = ACC_ST_IDLE;
                    s_d.cnt = 5'h0;
                end
            endcase
        end
        busy = s_q.st != ACC_ST_IDLE;
        sampling = s_q.st == ACC_ST_SAMP;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '{st: ACC_ST_IDLE, cnt: 5'h0};
        end else begin
            s_q <= s_d;
        end
    end
endmodule // acc_seq
`default_nettype wire

// file: acc_top.sv
// Converter control top: AHB-Lite register slave, flags, interrupts and result capture
`default_nettype none
module acc_top (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire acc_pkg::acc_ahb_req_t ahb_req,
    output acc_pkg::acc_ahb_rsp_t ahb_rsp,
    input wire logic stop_i,
    input wire logic [9:0] sar_value_i,
    input wire logic [15:0] port_dir_out_i,
    output logic [15:0] ch_sel_o,
    output logic sample_o,
    output logic lp_bias_o,
    output logic busy_o,
    output logic conv_req_o,
    output logic irq_o
);
    import acc_pkg::*;
    acc_regs_t s_q;
    acc_regs_t s_d;
    logic tick;
    logic busy;
    logic sampling;
    logic take;
    logic done;
    logic addr_ok;
    logic a_valid;
    logic a_read;
    logic [4:0] a_off;
    logic [31:0] wd;
    logic rd_result;
    logic wr_ctrl;
    logic [2:0] ev;
    logic [2:0] w1c;
    logic ch_valid;

    acc_clkgen u_clkgen (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .async_clock_enable(s_q.async_clock_enable),
        .div(s_q.div),
        .stop_i(stop_i),
        .tick(tick)
    );

    acc_seq u_seq (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .tick(tick),
        .start(s_q.start),
        .abort(s_q.abort),
        .long_smp(s_q.lsmp),
        .async_clock_enable(s_q.async_clock_enable),
        .busy(busy),
        .sampling(sampling),
        .take(take),
        .done(done)
    );

    always_comb begin
        s_d = s_q;
        s_d.start = 1'b0;
        s_d.abort = 1'b0;
        wd = ahb_req.hwdata;

        // Address phase decode; only the low window of 32 bytes is mapped
        a_valid = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1];
        addr_ok = ahb_req.haddr[31:5] == 27'h0;
        a_off = addr_ok ? {ahb_req.haddr[4:2], 2'b00} : 5'h1c;
        a_read = a_valid & ~ahb_req.hwrite;

        // Data phase of a write
        wr_ctrl = 1'b0;
        w1c = 3'h0;
        if (s_q.wr_pend) begin
            unique case (s_q.wr_off)
                ACC_OFF_CTRL: begin
                    // Done flag bit is not taken from the write data
                    wr_ctrl = 1'b1;
                    s_d.irq_en = wd[ACC_CTRL_IEN];
                    s_d.cont = wd[ACC_CTRL_CONT];
                    s_d.chan = wd[ACC_CTRL_CH_LSB +: 5];
                end
                ACC_OFF_CLKREG: begin
                    s_d.async_clock_enable = wd[ACC_CLK_ASYNC_EN];
                    s_d.div = wd[ACC_CLK_DIV_LSB +: 2];
                    s_d.lpc = wd[ACC_CLK_LPC];
                    s_d.lsmp = wd[ACC_CLK_LSMP];
                end
                ACC_OFF_IST: begin
                    w1c = wd[2:0];
                end
                ACC_OFF_IMASK: begin
                    s_d.imask = wd[2:0];
                end
                default: begin
                    w1c = 3'h0;
                end
            endcase
        end

        // A write to control restarts, or stops when the channel is off
        ch_valid = s_d.chan[4] == 1'b0;
        if (wr_ctrl) begin
            s_d.start = ch_valid;
            s_d.abort = ~ch_valid;
        end else if (done && s_q.cont && ch_valid) begin
            s_d.start = 1'b1;
        end

        // Pin level is captured at the end of the sample phase
        if (take) begin
            s_d.held = sar_value_i;
        end

        // Events; a set in the same cycle as a clear wins
        ev = 3'h0;
        ev[ACC_EV_DONE] = done;
        ev[ACC_EV_OVR] = done & s_q.done;
        // Output driver on a sampled pin corrupts the reading
        ev[ACC_EV_DIR] = take & port_dir_out_i[s_q.chan[3:0]];
        s_d.ist = (s_q.ist & ~w1c) | ev;

        // Reading the result or writing control clears the done flag
        rd_result = a_read & (a_off == ACC_OFF_RESULT);
        if (done) begin
            // Set on every completion, interrupt enable or not
            s_d.done = 1'b1;
            // Right-justified in the low bits only
            s_d.result = s_q.held;
        end else if (rd_result || wr_ctrl) begin
            s_d.done = 1'b0;
        end

        // Next write data phase
        s_d.wr_pend = a_valid & ahb_req.hwrite;
        s_d.wr_off = a_off;

        // Read data from the next state so a write just before is seen
        if (a_read) begin
            unique case (a_off)
                ACC_OFF_CTRL: begin
                    s_d.rdata = {24'h0, s_d.done, s_d.irq_en, s_d.cont, s_d.chan};
                end
                ACC_OFF_RESULT: begin
                    // Read value is the stored result, before any clear
                    s_d.rdata = {22'h0, s_d.result};
                end
                ACC_OFF_CLKREG: begin
                    s_d.rdata = {24'h0, s_d.async_clock_enable, s_d.div, s_d.lpc, s_d.lsmp, 3'h0};
                end
                ACC_OFF_IST: begin
                    s_d.rdata = {29'h0, s_d.ist};
                end
                ACC_OFF_IMASK: begin
                    s_d.rdata = {29'h0, s_d.imask};
                end
                default: begin
                    s_d.rdata = 32'h0;
                end
            endcase
        end else begin
            s_d.rdata = 32'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '{
                wr_pend: 1'b0,
                wr_off: 5'h0,
                rdata: 32'h0,
                irq_en: 1'b0,
                cont: 1'b0,
                chan: ACC_RST_CH,
                async_clock_enable: 1'b0,
                div: ACC_RST_DIV,
                lpc: 1'b0,
                lsmp: 1'b0,
                done: 1'b0,
                result: 10'h0,
                held: 10'h0,
                ist: 3'h0,
                imask: ACC_RST_IMASK,
                start: 1'b0,
                abort: 1'b0
            };
        end else begin
            s_q <= s_d;
        end
    end

    // Zero-wait slave; every access answers OKAY
    assign ahb_rsp.hreadyout = 1'b1;
    assign ahb_rsp.hresp = 1'b0;
    assign ahb_rsp.hrdata = s_q.rdata;

    // Mux select only; pin digital buffers are left alone
    genvar gi;
    generate
        for (gi = 0; gi < ACC_NUM_CH; gi++) begin : g_ch
            assign ch_sel_o[gi] = busy & (s_q.chan == 5'(gi));
        end
    endgenerate

    // An abort lands one cycle after the channel goes off; never sample with no channel
    assign sample_o = sampling & ~s_q.chan[4];
    assign lp_bias_o = s_q.lpc;
    assign busy_o = busy;
    assign conv_req_o = s_q.done & s_q.irq_en;
    assign irq_o = |(s_q.ist & s_q.imask);
endmodule // acc_top
`default_nettype wire

// file: acc_top_properties.sv
// Checker of bus, flag and timing relations at the converter control ports
`default_nettype none
module acc_top_properties (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire acc_pkg::acc_ahb_req_t ahb_req,
    input wire acc_pkg::acc_ahb_rsp_t ahb_rsp,
    input wire logic stop_i,
    input wire logic [15:0] ch_sel_o,
    input wire logic sample_o,
    input wire logic lp_bias_o,
    input wire logic busy_o,
    input wire logic conv_req_o,
    input wire logic irq_o
);
    import acc_pkg::*;
    logic [2:0] ph_q;
    logic [5:0] n_q;
    wire logic ap = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
    wire logic [4:0] a = ahb_req.haddr[4:0];
    wire logic w = ahb_req.hwrite;
    // Data phase flags: read, clock register write, done flag clear
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ph_q <= 3'h0;
            n_q <= 6'h0;
        end else begin
            ph_q <= {ap && !w, ap && w && a == ACC_OFF_CLKREG,
                ap && (w ? a == ACC_OFF_CTRL : a == ACC_OFF_RESULT)};
            // A bus clear in mid-conversion may legally abort, so exempt it
            n_q <= !busy_o ? 6'h0 : (ph_q[0] ? 6'h3f : n_q + 6'(n_q != 6'h3f));
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    bus_okay_a: assert property (ahb_rsp.hreadyout && !ahb_rsp.hresp)
        else $error("bus answer not ready or not okay");
    rdata_idle_a: assert property (!ph_q[2] |-> ahb_rsp.hrdata == 32'h0)
        else $error("read data outside read data phase");
    sel_busy_a: assert property (ch_sel_o != 16'h0 |-> busy_o && $onehot(ch_sel_o))
        else $error("channel select bad");
    sample_busy_a: assert property (sample_o |-> busy_o && ch_sel_o != 16'h0)
        else $error("sampling without selected channel");
    conv_len_a: assert property ($fell(busy_o) |-> $past(n_q) >= 6'd20)
        else $error("conversion too short");
    lp_bias_a: assert property ($changed(lp_bias_o) |-> $past(ph_q[1]) &&
        lp_bias_o == $past(ahb_req.hwdata[ACC_CLK_LPC])) else $error("low power bit bad");
    req_rise_a: assert property ($rose(conv_req_o) |-> $past(busy_o) || $past(busy_o, 2))
        else $error("request without finished conversion");
    req_fall_a: assert property ($fell(conv_req_o) |-> ph_q[0] || $past(ph_q[0]))
        else $error("done flag dropped without clear");
    cover property ($rose(conv_req_o));
    cover property (sample_o && stop_i);
    cover property ($rose(irq_o));
endmodule // acc_top_properties
bind acc_top acc_top_properties u_props (.clk_sys(clk_sys), .arst_n(arst_n),
    .ahb_req(ahb_req), .ahb_rsp(ahb_rsp), .stop_i(stop_i), .ch_sel_o(ch_sel_o),
    .sample_o(sample_o), .lp_bias_o(lp_bias_o), .busy_o(busy_o),
    .conv_req_o(conv_req_o), .irq_o(irq_o));
`default_nettype wire

// file: acc_pins_model.sv
// Model of the analog pins and the port direction logic beside the converter
`default_nettype none
module acc_pins_model (
    input wire logic clk_sys,
    input wire logic [15:0] ch_sel_o,
    input wire logic sample_o,
    input wire logic drive_out,
    output logic [9:0] sar_value_i,
    output logic [15:0] port_dir_out_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] junk_q = 10'h2aa;
    // Pins stay inputs unless a scenario asks for a misconfigured port
    assign port_dir_out_i = drive_out ? 16'hffff : 16'h0000;
    // Outside sampling the level is noise, so a stale capture shows up
    always @(posedge clk_sys) junk_q <= ~junk_q;
    always_comb begin
        sar_value_i = junk_q;
        for (int i = 0; i < 16; i++) begin
            if (sample_o && ch_sel_o[i]) sar_value_i = {2'h2, 4'(i), 4'h5};
        end
    end
endmodule // acc_pins_model
`default_nettype wire

// file: tb_adc_conversion_control.sv
// Self-checking testbench of the converter control block
`default_nettype none
module tb_adc_conversion_control;
    timeunit 1ns;
    timeprecision 1ps;
    import acc_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic stop_i = 1'b0;
    logic drive_out = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [9:0] sar;
    logic [15:0] pdir, ch_sel, seen_sel;
    logic sample, lp_bias, busy, conv_req, irq;
    acc_ahb_req_t req;
    acc_ahb_rsp_t rsp;
    logic [31:0] rd;
    int bad_count = 0;
    int n_compared = 0;
    int n;
    assign req = {hsel, haddr, htrans, hwrite, 3'h2, hwdata, rsp.hreadyout};
    initial forever #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (sample === 1'b1) seen_sel <= ch_sel;
    acc_top DUT (.clk_sys(clk_sys), .arst_n(arst_n), .ahb_req(req), .ahb_rsp(rsp),
        .stop_i(stop_i), .sar_value_i(sar), .port_dir_out_i(pdir), .ch_sel_o(ch_sel),
        .sample_o(sample), .lp_bias_o(lp_bias), .busy_o(busy), .conv_req_o(conv_req),
        .irq_o(irq));
    acc_pins_model u_pins (.clk_sys(clk_sys), .ch_sel_o(ch_sel), .sample_o(sample),
        .drive_out(drive_out), .sar_value_i(sar), .port_dir_out_i(pdir));
    task automatic finish_test();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic hang(input int k, input int lim);
        if (k >= lim) begin
            bad_count++;
            finish_test();
        end
    endtask
    task automatic edge_rdy();
        int k;
        k = 0;
        @(posedge clk_sys);
        while (rsp.hreadyout !== 1'b1) begin
            k++;
            hang(k, 50);
            @(posedge clk_sys);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= ACC_HTRANS_NONSEQ;
        haddr <= {27'h0, a};
        hwrite <= w;
        edge_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        edge_rdy();
        rd = rsp.hrdata;
    endtask
    // Counts cycles of one conversion, from busy seen high until it drops
    task automatic conv(input int lim);
        int k;
        n = 0;
        for (k = 0; k < lim && !(n > 0 && busy !== 1'b1); k++) begin
            @(posedge clk_sys);
            if (busy === 1'b1) n++;
        end
        hang(k, lim);
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic t_regs();
        bus(1'b1, 5'h14, 32'hffffffff);
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, 5'(i * 4), 32'h0);
            chk(rd, i == 0 ? 32'h1f : 32'h0);
        end
        $display("t_regs done");
    endtask
    task automatic t_len();
        logic [7:0] cv[7] = '{8'h00, 8'h08, 8'h80, 8'h88, 8'h20, 8'h60, 8'h97};
        int ce[7] = '{21, 41, 48, 88, 42, 168, 48};
        // Converter clock period in system cycles; first tick phase is free
        int pe[7] = '{1, 1, 2, 2, 2, 8, 2};
        for (int i = 0; i < 7; i++) begin
            bus(1'b1, ACC_OFF_CLKREG, {24'h0, cv[i]});
            bus(1'b0, ACC_OFF_CLKREG, 32'h0);
            chk(rd, {24'h0, cv[i] & 8'hf8});
            chk(32'(lp_bias), 32'(cv[i][4]));
            bus(1'b1, ACC_OFF_CTRL, 32'h3);
            conv(400);
            chk(32'(n > ce[i] - pe[i] - 2 && n < ce[i] + 3), 32'h1);
            bus(1'b0, ACC_OFF_CTRL, 32'h0);
            chk(rd, 32'h83);
            chk(32'(conv_req), 32'h0);
            bus(1'b0, ACC_OFF_RESULT, 32'h0);
            chk(rd, 32'h235);
        end
        bus(1'b1, ACC_OFF_CLKREG, 32'h0);
        $display("t_len done");
    endtask
    task automatic t_irq();
        bus(1'b1, ACC_OFF_IST, 32'h7);
        bus(1'b1, ACC_OFF_IMASK, 32'h1);
        bus(1'b1, ACC_OFF_CTRL, 32'h45);
        conv(100);
        chk({30'h0, conv_req, irq}, 32'h3);
        bus(1'b1, ACC_OFF_IMASK, 32'h0);
        @(posedge clk_sys);
        chk(32'(irq), 32'h0);
        bus(1'b0, ACC_OFF_RESULT, 32'h0);
        @(posedge clk_sys);
        chk(32'(conv_req), 32'h0);
        bus(1'b1, ACC_OFF_IST, 32'h1);
        bus(1'b1, ACC_OFF_IMASK, 32'h1);
        @(posedge clk_sys);
        chk(32'(irq), 32'h0);
        bus(1'b1, ACC_OFF_CTRL, 32'h9f);
        bus(1'b0, ACC_OFF_CTRL, 32'h0);
        chk(rd, 32'h1f);
        $display("t_irq done");
    endtask
    task automatic t_pin();
        drive_out <= 1'b1;
        bus(1'b1, ACC_OFF_CTRL, 32'h7);
        conv(100);
        chk(32'(seen_sel), 32'h80);
        bus(1'b0, ACC_OFF_RESULT, 32'h0);
        chk(rd, 32'h275);
        bus(1'b0, ACC_OFF_IST, 32'h0);
        chk(32'(rd[ACC_EV_DIR]), 32'h1);
        drive_out <= 1'b0;
        $display("t_pin done");
    endtask
    task automatic t_stop();
        bus(1'b1, ACC_OFF_CLKREG, 32'h80);
        bus(1'b1, ACC_OFF_CTRL, 32'h2);
        stop_i <= 1'b1;
        conv(200);
        bus(1'b0, ACC_OFF_CTRL, 32'h0);
        chk(rd, 32'h82);
        bus(1'b1, ACC_OFF_CLKREG, 32'h0);
        bus(1'b1, ACC_OFF_CTRL, 32'h2);
        repeat (100) @(posedge clk_sys);
        chk(32'(busy), 32'h1);
        stop_i <= 1'b0;
        conv(100);
        bus(1'b0, ACC_OFF_CTRL, 32'h0);
        chk(rd, 32'h82);
        $display("t_stop done");
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        t_regs();
        t_len();
        t_irq();
        t_pin();
        t_stop();
        finish_test();
    end
endmodule // tb_adc_conversion_control
`default_nettype wire
